// file: common/rch_defs.svh
`ifndef RCH_DEFS_SVH
`define RCH_DEFS_SVH
// control byte bit positions
`define RCH_CTL_INIT      3'd0
`define RCH_CTL_HEADINFO  3'd1
`define RCH_CTL_TAGINFO   3'd2
`define RCH_CTL_STORE     3'd3
`define RCH_CTL_FETCH     3'd4
`define RCH_CTL_IDENT     3'd5
`define RCH_CTL_NEXT      3'd6
`define RCH_CTL_HEAD_EN   3'd7
// status byte bit positions
`define RCH_ST_TRANSFER   3'd1
`define RCH_ST_PRESENT    3'd2
`define RCH_ST_HEAD_ON    3'd3
`define RCH_ST_ATTACHED   3'd4
`define RCH_ST_ERROR      3'd5
`define RCH_ST_BUSY       3'd6
`define RCH_ST_DONE       3'd7
// apb register byte addresses
`define RCH_ADDR_CTRL     12'h000
`define RCH_ADDR_STATUS   12'h004
`define RCH_ADDR_ERRCODE  12'h008
`define RCH_ADDR_IRQ_ST   12'h00C
`define RCH_ADDR_IRQ_MASK 12'h010
`define RCH_ADDR_INIT_LEN 12'h014
// reset values and timing
`define RCH_CTRL_RST      8'h00
`define RCH_MASK_RST      8'h00
`define RCH_INIT_CYC_RST  16'h0010
// interrupt status bits
`define RCH_IRQ_HEAD_ON   3'd0
`define RCH_IRQ_INIT_DONE 3'd1
`define RCH_IRQ_CMD_DROP  3'd2
`define RCH_IRQ_ERROR     3'd3
`endif

// file: common/rch_pkg.sv
package rch_pkg;
    typedef struct packed {
        logic        paddr_ok;
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } rch_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rch_apb_rsp_t;

    typedef enum logic [1:0] {
        RCH_OFF   = 2'b00,
        RCH_IDLE  = 2'b01,
        RCH_INIT  = 2'b10
    } rch_state_t;
endpackage : rch_pkg

// file: hw/rch_channel.sv
// Notes on behaviour
// - head is switched on when control bit 7 rises, e.g. byte 128
// - connected, active, idle head reports status 152 (bits 3, 4, 7)
// - init starts on rising bit 0 while head enabled, e.g. byte 129
// - control byte holds one command per bit, bit 7 head enable
// - status bits: transfer, present, on, connected, error, busy, done
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "rch_defs.svh"
module rch_channel #(
    parameter logic [15:0] INIT_CYCLES = `RCH_INIT_CYC_RST
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_head_attached,
    input  wire logic        i_carrier_present,
    output logic             o_head_enable,
    output logic             o_irq
);
    rch_pkg::rch_state_t state_reg;
    rch_pkg::rch_apb_rsp_t rsp;
    logic [1:0]  att_sync_reg;
    logic [1:0]  pres_sync_reg;
    logic        attached;
    logic        present;
    logic [7:0]  chan1_ctrl_image;
    logic [7:0]  ctrl_prev_reg;
    logic [7:0]  rise;
    logic        ctrl_wr;
    logic        stat_rd;
    logic        access;
    logic [15:0] init_cnt_reg;
    logic [15:0] init_len_reg;
    logic [7:0]  irq_st_reg;
    logic [7:0]  irq_st_next;
    logic [7:0]  irq_mask_reg;
    logic [15:0] err_code_reg;
    logic        error_reg;
    logic        head_on;
    logic        busy;
    logic [7:0]  chan1_status_image;

    // head sense pins come from outside, two flops first
    // an unplugged head is seen two cycles late; harmless at fieldbus rates
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            att_sync_reg  <= 2'b00;
            pres_sync_reg <= 2'b00;
        end else begin
            att_sync_reg  <= {att_sync_reg[0], i_head_attached};
            pres_sync_reg <= {pres_sync_reg[0], i_carrier_present};
        end
    end
    assign attached = att_sync_reg[1];
    assign present  = pres_sync_reg[1];

    // apb decode, zero wait states
    // writes to unmapped offsets fall through every decode and are dropped
    assign access  = i_psel && i_penable;
    assign ctrl_wr = access && i_pwrite && (i_paddr == `RCH_ADDR_CTRL);
    assign stat_rd = access && !i_pwrite && (i_paddr == `RCH_ADDR_IRQ_ST);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chan1_ctrl_image <= `RCH_CTRL_RST;
        end else if (ctrl_wr) begin
            chan1_ctrl_image <= i_pwdata[7:0];
        end
    end

    // edge detect against previous image; a held bit never retriggers
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_prev_reg <= `RCH_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_prev_reg <= chan1_ctrl_image;
        end
    end
    assign rise = chan1_ctrl_image & ~ctrl_prev_reg;

    // head follows bit 7; off from enable low
    // the enable pin follows the image at once; the state tracks the edge
    assign o_head_enable = chan1_ctrl_image[`RCH_CTL_HEAD_EN];
    assign head_on = o_head_enable && attached && (state_reg != rch_pkg::RCH_OFF);

    // init length register
    // zero would wrap the countdown to 65536 cycles, so it is taken as one
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            init_len_reg <= INIT_CYCLES;
        end else if (access && i_pwrite && i_paddr == `RCH_ADDR_INIT_LEN) begin
            init_len_reg <= (i_pwdata[15:0] == 16'h0000) ? 16'h0001 : i_pwdata[15:0];
        end
    end

    // channel sequencer; only a fresh edge (one cycle after write) counts
    // strobe pulses once per written image, so a held bit is seen once
    logic edge_seen_reg;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            edge_seen_reg <= 1'b0;
        end else begin
            edge_seen_reg <= ctrl_wr;
        end
    end

    // channel state and init countdown
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg    <= rch_pkg::RCH_OFF;
            init_cnt_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                rch_pkg::RCH_OFF: begin
                    // rising head enable switches the head on
                    if (edge_seen_reg && rise[`RCH_CTL_HEAD_EN]) begin
                        state_reg <= rch_pkg::RCH_IDLE;
                    end
                end
                rch_pkg::RCH_IDLE: begin
                    if (!o_head_enable) begin
                        state_reg <= rch_pkg::RCH_OFF;
                    end else if (edge_seen_reg && rise[`RCH_CTL_INIT]) begin
                        state_reg    <= rch_pkg::RCH_INIT;
                        init_cnt_reg <= init_len_reg;
                    end
                end
                rch_pkg::RCH_INIT: begin
                    if (!o_head_enable) begin
                        state_reg <= rch_pkg::RCH_OFF;
                    end else if (init_cnt_reg == 16'h0001) begin
                        state_reg <= rch_pkg::RCH_IDLE;
                    end else begin
                        init_cnt_reg <= init_cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= rch_pkg::RCH_OFF;
                end
            endcase
        end
    end
    assign busy = (state_reg == rch_pkg::RCH_INIT);

    // error: command edge while head not ready; cleared by a good init
    // set wins: a refusal in the last init cycle keeps the error
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            error_reg    <= 1'b0;
            err_code_reg <= 16'h0000;
        end else if (edge_seen_reg && (|rise[6:0]) && !(head_on && !busy)) begin
            error_reg    <= 1'b1;
            err_code_reg <= {8'h00, rise};
        end else if (busy && init_cnt_reg == 16'h0001) begin
            error_reg    <= 1'b0;
            err_code_reg <= 16'h0000;
        end
    end

    // status image: bit 0 and transfer stay low here
    // done also reads high with the head off: nothing is pending
    always_comb begin
        chan1_status_image = 8'h00;
        chan1_status_image[`RCH_ST_PRESENT]  = present && head_on;
        chan1_status_image[`RCH_ST_HEAD_ON]  = head_on;
        chan1_status_image[`RCH_ST_ATTACHED] = attached;
        chan1_status_image[`RCH_ST_ERROR]    = error_reg;
        chan1_status_image[`RCH_ST_BUSY]     = busy;
        chan1_status_image[`RCH_ST_DONE]     = !busy && !error_reg;
    end

    // previous head-on level, so the head-on event is a one-cycle pulse
    logic head_on_prev_reg;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            head_on_prev_reg <= 1'b0;
        end else begin
            head_on_prev_reg <= head_on;
        end
    end

    // sticky events; set wins over clear-on-read
    always_comb begin
        // clear only the bits the read returned: an event landing between the
        // setup capture and the access edge would otherwise be lost
        irq_st_next = stat_rd ? (irq_st_reg & ~o_prdata[7:0]) : irq_st_reg;
        // head coming on, edge against the last cycle
        if (head_on && !head_on_prev_reg) begin
            irq_st_next[`RCH_IRQ_HEAD_ON] = 1'b1;
        end
        if (busy && init_cnt_reg == 16'h0001) begin
            irq_st_next[`RCH_IRQ_INIT_DONE] = 1'b1;
        end
        if (edge_seen_reg && (|rise[6:0]) && !(head_on && !busy)) begin
            irq_st_next[`RCH_IRQ_CMD_DROP] = 1'b1;
        end
    end
    // sticky status register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_st_reg <= 8'h00;
        end else begin
            irq_st_reg <= irq_st_next;
        end
    end
    // mask, same layout as the sticky status
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_mask_reg <= `RCH_MASK_RST;
        end else if (access && i_pwrite && i_paddr == `RCH_ADDR_IRQ_MASK) begin
            irq_mask_reg <= i_pwdata[7:0];
        end
    end
    assign o_irq = |(irq_st_reg & irq_mask_reg);

    // read mux, unmapped address answers slverr
    always_comb begin
        rsp.pready  = 1'b1;
        rsp.pslverr = 1'b0;
        rsp.prdata  = 32'h0000_0000;
        unique case (i_paddr)
            `RCH_ADDR_CTRL:     rsp.prdata = {24'h0, chan1_ctrl_image};
            `RCH_ADDR_STATUS:   rsp.prdata = {24'h0, chan1_status_image};
            `RCH_ADDR_ERRCODE:  rsp.prdata = {16'h0, err_code_reg};
            `RCH_ADDR_IRQ_ST:   rsp.prdata = {24'h0, irq_st_reg};
            `RCH_ADDR_IRQ_MASK: rsp.prdata = {24'h0, irq_mask_reg};
            `RCH_ADDR_INIT_LEN: rsp.prdata = {16'h0, init_len_reg};
            default:            rsp.pslverr = access;
        endcase
    end
    // read data is captured in the setup cycle so it stands through the
    // whole access phase; clear-on-read relies on that snapshot
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= rsp.prdata;
        end
    end
    assign o_pready  = rsp.pready;
    assign o_pslverr = rsp.pslverr;

    a_ready_status: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (head_on && !busy && !error_reg && !present) |-> chan1_status_image == 8'h98)
        else $error("ready status not 152");
    // head coming on leaves a sticky event
    a_head_event: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(head_on) |=> irq_st_reg[`RCH_IRQ_HEAD_ON])
        else $error("head-on event lost");
    a_head_switch: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == rch_pkg::RCH_OFF && edge_seen_reg && rise[7])
        |=> state_reg == rch_pkg::RCH_IDLE)
        else $error("head not switched on");
    // enable low drops the channel back to off
    a_head_drop: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg != rch_pkg::RCH_OFF && !o_head_enable)
        |=> state_reg == rch_pkg::RCH_OFF)
        else $error("head not switched off");
    // init starts after rising bit 0
    a_init_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == rch_pkg::RCH_IDLE && o_head_enable && edge_seen_reg && rise[0])
        |=> busy)
        else $error("init not started");
    // last counted init cycle with the head still enabled
    sequence s_init_last;
        busy && o_head_enable && (init_cnt_reg == 16'h0001);
    endsequence
    // init returns to idle and raises the done event
    a_init_finish: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        s_init_last |=> !busy && irq_st_reg[`RCH_IRQ_INIT_DONE])
        else $error("init did not finish");
    // no init without a fresh rising edge of bit 0
    a_no_retrig: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == rch_pkg::RCH_IDLE && !(edge_seen_reg && rise[`RCH_CTL_INIT]))
        |=> !busy)
        else $error("init without fresh edge");
    // command edge on bits 0 to 6 while the head is not ready
    sequence s_cmd_refused;
        edge_seen_reg && (|rise[6:0]) && !(head_on && !busy);
    endsequence
    // refusal shows as error and as the sticky drop event
    a_refuse_flag: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        s_cmd_refused |=> error_reg && irq_st_reg[`RCH_IRQ_CMD_DROP])
        else $error("refused command not flagged");
    a_busy_done: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !(chan1_status_image[6] && chan1_status_image[7]))
        else $error("busy with done");
    a_enable_bit: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ctrl_wr |=> o_head_enable == $past(i_pwdata[7]))
        else $error("enable not bit 7");
endmodule : rch_channel

// file: bench/rch_head_model.sv
`timescale 1ns/1ns
// head on the far side of the channel: reports attached while plugged in and
// sees a carrier only while its field is on
module rch_head_model (
    input  wire logic i_head_enable,
    input  wire logic i_plugged,
    input  wire logic i_tag_near,
    output logic      o_head_attached,
    output logic      o_carrier_present
);
    // attachment does not depend on the enable; a carrier needs the field
    assign o_head_attached   = i_plugged;
    assign o_carrier_present = i_head_enable & i_plugged & i_tag_near;
endmodule : rch_head_model

// file: bench/testbench.sv
`timescale 1ns/1ns
`include "rch_defs.svh"
module testbench;
    logic        i_clock = 1'b0, i_rst_b = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, head_en, irq, attached, present;
    logic        plugged = 1'b0, tag_near = 1'b0;
    integer      err_count = 0, num_checks = 0, seed = 57, i, b, r;
    always #50 i_clock = ~i_clock;
    rch_channel #(.INIT_CYCLES(16'h0008)) uut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_head_attached(attached),
        .i_carrier_present(present), .o_head_enable(head_en), .o_irq(irq));
    rch_head_model head (.i_head_enable(head_en), .i_plugged(plugged),
        .i_tag_near(tag_near), .o_head_attached(attached), .o_carrier_present(present));
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // setup cycle, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
        @(posedge i_clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin err_count = err_count + 1; stop_test(); end
        rd = prdata;
        b = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // status polling under a bound; running out ends the run
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        integer n;
        for (n = 0; n < 60; n++) begin
            apb(1'b0, `RCH_ADDR_STATUS, 32'h0);
            if ((rd & m) === v) begin chk(rd & m, v); return; end
        end
        err_count = err_count + 1;
        stop_test();
    endtask : poll
    initial begin
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        // done reads high with the head off: nothing is pending
        apb(1'b0, `RCH_ADDR_STATUS, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, 12'h0F0, 32'h0);
        chk(b, 1);
        apb(1'b0, `RCH_ADDR_INIT_LEN, 32'h0);
        chk(rd, 32'h8);
        apb(1'b1, `RCH_ADDR_IRQ_MASK, 32'h07);
        // head switched on by rising enable bit
        apb(1'b1, `RCH_ADDR_CTRL, 32'd128);
        // outputs launched at the access edge are looked at once settled
        @(negedge i_clock);
        chk(head_en, 1);
        apb(1'b0, `RCH_ADDR_CTRL, 32'h0); chk(rd, 32'd128);
        plugged <= 1'b1;
        poll(32'hFF, 32'd152);
        tag_near <= 1'b1;
        poll(32'hFF, 32'd156);
        tag_near <= 1'b0;
        chk(irq, 1);
        apb(1'b0, `RCH_ADDR_IRQ_ST, 32'h0);
        chk(rd & 7, 32'h01);
        @(negedge i_clock);
        chk(irq, 0);
        // init on rising bit 0, busy then done
        apb(1'b1, `RCH_ADDR_CTRL, 32'd129);
        apb(1'b0, `RCH_ADDR_STATUS, 32'h0); chk(rd[6], 1);
        poll(32'hFF, 32'd152);
        apb(1'b0, `RCH_ADDR_IRQ_ST, 32'h0); chk(rd & 7, 32'h02);
        // bit left high is not a second command
        apb(1'b1, `RCH_ADDR_CTRL, 32'd129);
        apb(1'b0, `RCH_ADDR_STATUS, 32'h0); chk(rd & 32'hFF, 32'd152);
        apb(1'b1, `RCH_ADDR_CTRL, 32'd128);
        apb(1'b1, `RCH_ADDR_CTRL, 32'd129);
        apb(1'b0, `RCH_ADDR_STATUS, 32'h0); chk(rd[6], 1);
        poll(32'hFF, 32'd152);
        apb(1'b1, `RCH_ADDR_CTRL, 32'd128);
        apb(1'b0, `RCH_ADDR_IRQ_ST, 32'h0);
        // commands with the head off are refused; masked refusal keeps irq low
        apb(1'b1, `RCH_ADDR_IRQ_MASK, 32'h03);
        for (i = 0; i < 3; i++) begin
            r = $unsigned($random(seed)) % 7;
            apb(1'b1, `RCH_ADDR_CTRL, 32'h00);
            apb(1'b1, `RCH_ADDR_CTRL, 32'h1 << r);
            poll(32'h20, 32'h20);
        end
        chk(irq, 0);
        apb(1'b0, `RCH_ADDR_ERRCODE, 32'h0);
        chk(rd, 32'h1 << r);
        apb(1'b1, `RCH_ADDR_IRQ_MASK, 32'h07);
        @(negedge i_clock);
        chk(irq, 1);
        apb(1'b0, `RCH_ADDR_IRQ_ST, 32'h0);
        chk(rd & 7, 32'h04);
        @(negedge i_clock);
        chk(irq, 0);
        stop_test();
    end
endmodule : testbench
